// ==== src/ists_pkg.sv ====
// constants shared by the two-wire slave with bus time-out
package ists_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_OWN = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_TOUT = 8'h10;
  localparam int ADDR_LSB_W = 8;

  // mode_enable_reg layout and reset
  localparam logic [7:0] MODE_RST = 8'he0;
  localparam int MODE_FIELD_LSB = 5;
  localparam int MODE_UART_BIT = 4;
  localparam int MODE_EN_BIT = 1;
  localparam logic [2:0] MODE_SLAVE = 3'h6;
  localparam logic [7:0] MODE_WMASK = 8'hfe;

  // bus_status_ctl_reg bit positions and reset
  localparam int STAT_DONE = 7;
  localparam int STAT_MATCH = 6;
  localparam int STAT_BUSY = 5;
  localparam int STAT_HTX = 4;
  localparam int STAT_ACK_TO_SEND_BIT = 3;
  localparam int STAT_SRW = 2;
  localparam int STAT_ACK_RECEIVED_FLAG = 0;
  localparam logic STAT_DONE_RST = 1'b1;
  localparam logic STAT_ACK_RECEIVED_FLAG_RST = 1'b1;

  // own_address_reg holds the address in bits 7:1
  localparam int OWN_LSB = 1;

  // timeout_ctl_reg layout
  localparam int TOUT_EN_BIT = 7;
  localparam int TOUT_FLAG_BIT = 6;
  localparam int TOUT_SEL_W = 6;
  localparam int TOUT_CNT_W = 12;
  localparam int TOUT_STEP_SHIFT = 5;

  // serial framing
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACKOUT = 8'h04,
    ST_HOLD = 8'h08,
    ST_TX = 8'h10,
    ST_ACKIN = 8'h20,
    ST_RX = 8'h40,
    ST_IGNORE = 8'h80
  } ists_state_t;

endpackage

// ==== src/ists_sync.sv ====
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module ists_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else if (ce)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== src/ists_timeout.sv ====
// bus time-out counter paced by sub-clock ticks
`timescale 1ns/1ps
module ists_timeout (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic sub_tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [ists_pkg::TOUT_SEL_W-1:0] period_sel,
  output logic expire
);

  logic [ists_pkg::TOUT_CNT_W-1:0] cnt_reg;
  logic [ists_pkg::TOUT_CNT_W-1:0] cnt_next;
  logic [ists_pkg::TOUT_CNT_W-1:0] limit;

  // (n+1) steps of 32 sub-clock periods
  assign limit = {({1'b0, period_sel} + 7'h01),
                  {ists_pkg::TOUT_STEP_SHIFT{1'b0}}};
  assign cnt_next = cnt_reg + 12'h001;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= '0;
      expire <= 1'b0;
    end
    else if (ce)
    begin
      expire <= 1'b0;
      if (!run || restart)
        cnt_reg <= '0;
      else if (sub_tick)
      begin
        cnt_reg <= cnt_next;
        if (cnt_next == limit)
          expire <= 1'b1;
      end
    end
  end

endmodule

// ==== src/ists_i2c_slave.sv ====
// two-wire bus slave with time-out, registers over ahb-lite
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module ists_i2c_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic slow_sub_clock,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic serial_irq
);

  // pin synchronisation and edge detection
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic sub_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic sub_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sub_tick;

  ists_sync #(
    .W(3),
    .RST_VAL(3'h3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .async_in({slow_sub_clock, scl_i, sda_i}),
    .sync_out(pins_sync)
  );

  assign sda_s = pins_sync[0];
  assign scl_s = pins_sync[1];
  assign sub_s = pins_sync[2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      sub_prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      sub_prev_reg <= sub_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_ev = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_ev = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign sub_tick = sub_s & ~sub_prev_reg;

  // registers
  logic [7:0] mode_enable_reg;
  logic [ists_pkg::ADDR_W-1:0] own_address_reg;
  logic [ists_pkg::BYTE_W-1:0] serial_data_reg;
  logic timeout_enable_bit;
  logic timeout_flag;
  logic [ists_pkg::TOUT_SEL_W-1:0] timeout_period_sel;
  logic byte_done_flag;
  logic addr_match_flag;
  logic bus_busy_flag;
  logic transmit_direction_ctl;
  logic ack_to_send_bit;
  logic master_read_flag;
  logic ack_received_flag;
  logic slave_active;
  logic [2:0] interface_mode_field;
  logic uart_select_bit;
  logic interface_enable_bit;

  assign interface_mode_field =
    mode_enable_reg[ists_pkg::MODE_FIELD_LSB +: 3];
  assign uart_select_bit = mode_enable_reg[ists_pkg::MODE_UART_BIT];
  assign interface_enable_bit = mode_enable_reg[ists_pkg::MODE_EN_BIT];
  assign slave_active = ~uart_select_bit && interface_enable_bit &&
                        (interface_mode_field == ists_pkg::MODE_SLAVE);

  // ahb-lite slave, zero wait states
  logic acc;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_ev;
  logic wr_data_ev;
  logic rd_data_ev;

  function automatic logic [7:0] reg_sel(input logic [31:0] a);
    reg_sel = a[ists_pkg::ADDR_LSB_W-1:0];
  endfunction

  assign acc = hsel & hready & htrans[1] & ce;
  assign wr_ev = wr_pend_reg & ce;
  assign wr_data_ev = wr_ev && (wr_addr_reg == ists_pkg::ADDR_DATA);
  assign rd_data_ev = acc && !hwrite &&
                      (reg_sel(haddr) == ists_pkg::ADDR_DATA);
  assign hreadyout = ce;
  assign hresp = 1'b0;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ists_pkg::ADDR_MODE: v = mode_enable_reg;
      ists_pkg::ADDR_STAT:
      begin
        v[ists_pkg::STAT_DONE] = byte_done_flag;
        v[ists_pkg::STAT_MATCH] = addr_match_flag;
        v[ists_pkg::STAT_BUSY] = bus_busy_flag;
        v[ists_pkg::STAT_HTX] = transmit_direction_ctl;
        v[ists_pkg::STAT_ACK_TO_SEND_BIT] = ack_to_send_bit;
        v[ists_pkg::STAT_SRW] = master_read_flag;
        v[ists_pkg::STAT_ACK_RECEIVED_FLAG] = ack_received_flag;
      end
      ists_pkg::ADDR_OWN: v = {own_address_reg, 1'b0};
      ists_pkg::ADDR_DATA: v = serial_data_reg;
      ists_pkg::ADDR_TOUT:
        v = {timeout_enable_bit, timeout_flag, timeout_period_sel};
      default: v = 8'h00;
    endcase
    read_word = {24'h000000, v};
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else if (ce)
    begin
      wr_pend_reg <= acc & hwrite;
      if (acc)
        wr_addr_reg <= reg_sel(haddr);
      if (acc && !hwrite)
        hrdata <= read_word(reg_sel(haddr));
    end
  end

  // serial engine
  ists_pkg::ists_state_t st_reg;
  logic [ists_pkg::BYTE_W-1:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic sda_drv_reg;
  logic ack_low_reg;
  logic ack_half_reg;
  logic [ists_pkg::BYTE_W-1:0] in_byte;
  logic [ists_pkg::BYTE_W-1:0] tx_byte;
  logic addr_hit;
  logic ev_match;
  logic ev_byte_rx;
  logic ev_byte_tx;
  logic release_ev;
  logic expire;

  assign in_byte = {shift_reg[ists_pkg::BYTE_W-2:0], sda_s};
  assign addr_hit = in_byte[ists_pkg::BYTE_W-1:1] == own_address_reg;
  assign ev_match = (st_reg == ists_pkg::ST_ADDR) && scl_rise &&
                    (bit_cnt_reg == ists_pkg::LAST_BIT) && addr_hit
                    && !start_ev;
  assign ev_byte_rx = (st_reg == ists_pkg::ST_RX) && scl_rise &&
                      (bit_cnt_reg == ists_pkg::LAST_BIT);
  assign ev_byte_tx = (st_reg == ists_pkg::ST_TX) && scl_rise &&
                      (bit_cnt_reg == ists_pkg::LAST_BIT);
  assign release_ev = (st_reg == ists_pkg::ST_HOLD) &&
                      (wr_data_ev || rd_data_ev);
  assign tx_byte = wr_data_ev ? hwdata[ists_pkg::BYTE_W-1:0]
                              : serial_data_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= ists_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      sda_drv_reg <= 1'b0;
      ack_low_reg <= 1'b0;
      ack_half_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (expire || !slave_active)
      begin
        st_reg <= ists_pkg::ST_IDLE;
        sda_drv_reg <= 1'b0;
        ack_half_reg <= 1'b0;
      end
      else if (start_ev)
      begin
        st_reg <= ists_pkg::ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_drv_reg <= 1'b0;
        ack_half_reg <= 1'b0;
      end
      else if (stop_ev)
      begin
        st_reg <= ists_pkg::ST_IDLE;
        sda_drv_reg <= 1'b0;
        ack_half_reg <= 1'b0;
      end
      else
      begin
        case (st_reg)
          ists_pkg::ST_ADDR:
            if (scl_rise)
            begin
              shift_reg <= in_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == ists_pkg::LAST_BIT)
              begin
                ack_low_reg <= 1'b1;
                st_reg <= addr_hit ? ists_pkg::ST_ACKOUT
                                   : ists_pkg::ST_IGNORE;
              end
            end
          ists_pkg::ST_ACKOUT:
            if (scl_fall)
            begin
              if (!ack_half_reg)
              begin
                sda_drv_reg <= ack_low_reg;
                ack_half_reg <= 1'b1;
              end
              else
              begin
                sda_drv_reg <= 1'b0;
                ack_half_reg <= 1'b0;
                st_reg <= ists_pkg::ST_HOLD;
              end
            end
          ists_pkg::ST_HOLD:
            if (release_ev)
            begin
              bit_cnt_reg <= 4'h0;
              if (transmit_direction_ctl)
              begin
                shift_reg <= tx_byte;
                sda_drv_reg <= ~tx_byte[ists_pkg::BYTE_W-1];
                st_reg <= ists_pkg::ST_TX;
              end
              else
                st_reg <= ists_pkg::ST_RX;
            end
          ists_pkg::ST_TX:
            if (scl_rise)
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            else if (scl_fall)
            begin
              if (bit_cnt_reg == ists_pkg::BYTE_BITS)
              begin
                sda_drv_reg <= 1'b0;
                st_reg <= ists_pkg::ST_ACKIN;
              end
              else
              begin
                shift_reg <= {shift_reg[ists_pkg::BYTE_W-2:0], 1'b0};
                sda_drv_reg <= ~shift_reg[ists_pkg::BYTE_W-2];
              end
            end
          ists_pkg::ST_ACKIN:
            if (scl_rise)
            begin
              if (sda_s)
                st_reg <= ists_pkg::ST_IGNORE;
              else
                ack_half_reg <= 1'b1;
            end
            else if (scl_fall && ack_half_reg)
            begin
              ack_half_reg <= 1'b0;
              st_reg <= ists_pkg::ST_HOLD;
            end
          ists_pkg::ST_RX:
            if (scl_rise)
            begin
              shift_reg <= in_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == ists_pkg::LAST_BIT)
              begin
                ack_low_reg <= ~ack_to_send_bit;
                st_reg <= ists_pkg::ST_ACKOUT;
              end
            end
          ists_pkg::ST_IDLE: st_reg <= ists_pkg::ST_IDLE;
          ists_pkg::ST_IGNORE: st_reg <= ists_pkg::ST_IGNORE;
          default: st_reg <= ists_pkg::ST_IDLE;
        endcase
      end
    end
  end

  assign scl_o = 1'b0;
  assign scl_oe = (st_reg == ists_pkg::ST_HOLD);
  assign sda_o = 1'b0;
  assign sda_oe = sda_drv_reg;

  // software registers that the time-out leaves alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_enable_reg <= ists_pkg::MODE_RST;
      own_address_reg <= '0;
      serial_data_reg <= '0;
    end
    else if (ce)
    begin
      if (wr_ev && wr_addr_reg == ists_pkg::ADDR_MODE)
        mode_enable_reg <= hwdata[7:0] & ists_pkg::MODE_WMASK;
      if (wr_ev && wr_addr_reg == ists_pkg::ADDR_OWN)
        own_address_reg <= hwdata[ists_pkg::OWN_LSB +: ists_pkg::ADDR_W];
      if (ev_byte_rx && !stop_ev && !start_ev && slave_active)
        serial_data_reg <= in_byte;
      else if (wr_data_ev)
        serial_data_reg <= hwdata[ists_pkg::BYTE_W-1:0];
    end
  end

  // status and control flags; time-out returns them to power-on values
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      byte_done_flag <= ists_pkg::STAT_DONE_RST;
      addr_match_flag <= 1'b0;
      bus_busy_flag <= 1'b0;
      transmit_direction_ctl <= 1'b0;
      ack_to_send_bit <= 1'b0;
      master_read_flag <= 1'b0;
      ack_received_flag <= ists_pkg::STAT_ACK_RECEIVED_FLAG_RST;
    end
    else if (ce)
    begin
      if (expire)
      begin
        byte_done_flag <= ists_pkg::STAT_DONE_RST;
        addr_match_flag <= 1'b0;
        bus_busy_flag <= 1'b0;
        transmit_direction_ctl <= 1'b0;
        ack_to_send_bit <= 1'b0;
        master_read_flag <= 1'b0;
        ack_received_flag <= ists_pkg::STAT_ACK_RECEIVED_FLAG_RST;
      end
      else if (!slave_active)
      begin
        byte_done_flag <= ists_pkg::STAT_DONE_RST;
        addr_match_flag <= 1'b0;
        bus_busy_flag <= 1'b0;
        master_read_flag <= 1'b0;
        ack_received_flag <= ists_pkg::STAT_ACK_RECEIVED_FLAG_RST;
      end
      else
      begin
        if (start_ev)
        begin
          bus_busy_flag <= 1'b1;
          addr_match_flag <= 1'b0;
        end
        else if (stop_ev)
          bus_busy_flag <= 1'b0;
        if (ev_match)
        begin
          addr_match_flag <= 1'b1;
          master_read_flag <= in_byte[0];
        end
        if (release_ev)
          byte_done_flag <= 1'b0;
        else if ((ev_byte_rx || ev_byte_tx) && !start_ev && !stop_ev)
          byte_done_flag <= 1'b1;
        if (st_reg == ists_pkg::ST_ACKIN && scl_rise && !stop_ev)
          ack_received_flag <= sda_s;
        if (wr_ev && wr_addr_reg == ists_pkg::ADDR_STAT)
        begin
          transmit_direction_ctl <= hwdata[ists_pkg::STAT_HTX];
          ack_to_send_bit <= hwdata[ists_pkg::STAT_ACK_TO_SEND_BIT];
        end
      end
    end
  end

  // time-out control
  logic tout_run_reg;
  logic tout_wr;

  assign tout_wr = wr_ev && (wr_addr_reg == ists_pkg::ADDR_TOUT);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tout_run_reg <= 1'b0;
    else if (ce)
    begin
      if (expire || stop_ev || !slave_active || !timeout_enable_bit)
        tout_run_reg <= 1'b0;
      else if (ev_match && !start_ev)
        tout_run_reg <= 1'b1;
    end
  end

  ists_timeout u_timeout (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .sub_tick(sub_tick),
    .run(tout_run_reg),
    .restart(scl_fall),
    .period_sel(timeout_period_sel),
    .expire(expire)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timeout_enable_bit <= 1'b0;
      timeout_flag <= 1'b0;
      timeout_period_sel <= '0;
    end
    else if (ce)
    begin
      if (tout_wr)
      begin
        timeout_enable_bit <= hwdata[ists_pkg::TOUT_EN_BIT];
        timeout_flag <= hwdata[ists_pkg::TOUT_FLAG_BIT];
        timeout_period_sel <= hwdata[ists_pkg::TOUT_SEL_W-1:0];
      end
      // set wins over a same-cycle software write
      if (expire)
      begin
        timeout_enable_bit <= 1'b0;
        timeout_flag <= 1'b1;
      end
    end
  end

  // one shared interrupt pulse
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      serial_irq <= 1'b0;
    else if (ce)
      serial_irq <= ev_match | ((ev_byte_rx | ev_byte_tx) & slave_active)
                    | expire;
  end

endmodule

// ==== verif/ists_props.sv ====
// port checker for the two-wire slave
`timescale 1ns/1ps
module ists_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic serial_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic act;
  logic wpend_reg;
  logic [2:0] dcnt_reg;
  logic [7:0] mode_reg;
  assign take = hsel && hready && htrans[1] && ce;
  assign act = mode_reg[7:5] == ists_pkg::MODE_SLAVE && !mode_reg[4]
    && mode_reg[1];
  // recent data register access window
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dcnt_reg <= 3'h0;
    else if (take && haddr[7:0] == ists_pkg::ADDR_DATA)
      dcnt_reg <= 3'h6;
    else if (dcnt_reg != 3'h0)
      dcnt_reg <= dcnt_reg - 3'h1;
  end
  // shadow of the mode register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wpend_reg <= 1'b0;
      mode_reg <= ists_pkg::MODE_RST;
    end
    else if (hready)
    begin
      if (wpend_reg)
        mode_reg <= hwdata[7:0];
      wpend_reg <= take && hwrite && haddr[7:0] == ists_pkg::ADDR_MODE;
    end
  end
  property p_no_start;
    $rose(sda_oe) |-> !$past(scl_i);
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("data pulled low while clock high");
  property p_no_stop;
    $fell(sda_oe) |-> !$past(scl_i);
  endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("data released while clock high");
  property p_stretch_low;
    $rose(scl_oe) |-> !$past(scl_i);
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("stretch began with clock high");
  property p_release;
    $fell(scl_oe) |-> dcnt_reg != 3'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("stretch released without data access");
  property p_irq_pulse;
    serial_irq |=> !serial_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  property p_idle_off;
    (!act) [*3] |-> !sda_oe && !scl_oe;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("lines driven while inactive");
  property p_irq_act;
    serial_irq |-> act || $past(act);
  endproperty
  a_irq_act: assert property (p_irq_act)
    else $error("interrupt while inactive");
  property p_okay;
    hresp == 1'b0 && hreadyout == ce;
  endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");
endmodule
bind ists_i2c_slave ists_props u_props (.hclk, .hresetn, .ce, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .scl_i, .scl_oe, .sda_oe, .serial_irq);

// ==== verif/ists_master.sv ====
// behavioural two-wire bus master
`timescale 1ns/1ps
module ists_master (
  input wire logic hclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // release clock, wait out any stretch
  task automatic hi();
    scl_low <= 1'b0;
    @(posedge hclk);
    while (scl !== 1'b1)
      @(posedge hclk);
  endtask
  task automatic start();
    tk(2);
    sda_low <= 1'b0;
    tk(2);
    hi();
    tk(4);
    sda_low <= 1'b1;
    tk(4);
    scl_low <= 1'b1;
  endtask
  task automatic bitx(input logic b, output logic r);
    tk(2);
    sda_low <= !b;
    tk(2);
    hi();
    tk(2);
    r = sda;
    tk(1);
    scl_low <= 1'b1;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      bitx(d[i], r[i]);
    // let the slave's stretch begin before software touches data
    tk(4);
  endtask
  task automatic stop();
    tk(2);
    sda_low <= 1'b1;
    tk(2);
    hi();
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic sub_clk = 1'b0, k = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, scl_oe, sda_oe, irq, m_scl, m_sda, scl, sda;
  logic scl_o, sda_o;
  logic [6:0] own;
  logic [5:0] sel;
  logic [7:0] v, q;
  logic [8:0] r;
  int num_errors, check_count, cyc, irqs, base, n;
  assign scl = !m_scl && (scl_oe ? scl_o : 1'b1);
  assign sda = !m_sda && (sda_oe ? sda_o : 1'b1);
  ists_i2c_slave DUT (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .scl_i(scl), .sda_i(sda), .slow_sub_clock(sub_clk),
    .scl_o, .scl_oe, .sda_o, .sda_oe, .serial_irq(irq));
  ists_master mst (.hclk, .scl, .sda, .scl_low(m_scl), .sda_low(m_sda));
  always #5 hclk = ~hclk;
  always
  begin
    repeat (2) @(posedge hclk);
    sub_clk <= ~sub_clk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (irq === 1'b1)
      irqs++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] o);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= ists_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    o = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] o;
    acc(1'b1, a, d, o);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] o;
    acc(1'b0, a, 8'h0, o);
    chk(o, e);
  endtask
  function automatic logic [7:0] st(input logic d, m, b, t, a, w, x);
    st = {d, m, b, t, a, w, 1'b0, x};
  endfunction
  function automatic int tlim(input logic [5:0] s);
    return (int'(s) + 1) * 32;
  endfunction
  initial
  begin
    void'($urandom(32'h9bea0136));
    own = 7'($urandom_range(8, 119));
    sel = 6'($urandom_range(0, 3));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(ists_pkg::ADDR_MODE, ists_pkg::MODE_RST);
    rc(ists_pkg::ADDR_STAT, st(1, 0, 0, 0, 0, 0, 1));
    rc(ists_pkg::ADDR_TOUT, 8'h00);
    wr(8'h14, 8'hff);
    rc(8'h14, 8'h00);
    wr(ists_pkg::ADDR_OWN, {own, 1'b0});
    rc(ists_pkg::ADDR_OWN, {own, 1'b0});
    mst.start();
    mst.xfer({own, 2'b01}, r);
    chk({7'h0, r[0]}, 8'h1);
    mst.stop();
    $display("test regs done");
    wr(ists_pkg::ADDR_MODE, 8'hcf);
    rc(ists_pkg::ADDR_MODE, 8'hce);
    wr(ists_pkg::ADDR_STAT, 8'hff);
    rc(ists_pkg::ADDR_STAT, st(1, 0, 0, 1, 1, 0, 1));
    wr(ists_pkg::ADDR_STAT, 8'h00);
    base = irqs;
    mst.start();
    mst.xfer({own, 2'b01}, r);
    chk({7'h0, r[0]}, 8'h0);
    acc(1'b0, ists_pkg::ADDR_STAT, 8'h0, q);
    chk(q & 8'h7f, st(0, 1, 1, 0, 0, 0, 1));
    acc(1'b0, ists_pkg::ADDR_DATA, 8'h0, q);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($urandom);
      k = (i == 3);
      wr(ists_pkg::ADDR_STAT, {4'h0, k, 3'h0});
      mst.xfer({v, 1'b1}, r);
      chk({7'h0, r[0]}, {7'h0, k});
      rc(ists_pkg::ADDR_STAT, st(1, 1, 1, 0, k, 0, 1));
      rc(ists_pkg::ADDR_DATA, v);
    end
    mst.stop();
    repeat (8) @(posedge hclk);
    acc(1'b0, ists_pkg::ADDR_STAT, 8'h0, q);
    chk({7'h0, q[ists_pkg::STAT_BUSY]}, 8'h0);
    chk(8'(irqs - base), 8'h5);
    $display("test receive done");
    base = irqs;
    mst.start();
    mst.xfer({own, 2'b11}, r);
    chk({7'h0, r[0]}, 8'h0);
    acc(1'b0, ists_pkg::ADDR_STAT, 8'h0, q);
    chk({7'h0, q[ists_pkg::STAT_SRW]}, 8'h1);
    wr(ists_pkg::ADDR_STAT, 8'h10);
    for (int i = 0; i < 2; i++)
    begin
      v = 8'($urandom);
      wr(ists_pkg::ADDR_DATA, v);
      mst.xfer({8'hff, 1'(i)}, r);
      chk(r[8:1], v);
      acc(1'b0, ists_pkg::ADDR_STAT, 8'h0, q);
      chk({7'h0, q[ists_pkg::STAT_ACK_RECEIVED_FLAG]}, 8'(i));
    end
    mst.stop();
    chk(8'(irqs - base), 8'h3);
    $display("test transmit done");
    base = irqs;
    mst.start();
    mst.xfer({own ^ 7'h01, 2'b01}, r);
    chk({7'h0, r[0]}, 8'h1);
    mst.xfer({8'h00, 1'b1}, r);
    chk({7'h0, r[0]}, 8'h1);
    mst.start();
    mst.xfer({own, 2'b01}, r);
    chk({7'h0, r[0]}, 8'h0);
    acc(1'b0, ists_pkg::ADDR_DATA, 8'h0, q);
    mst.stop();
    chk(8'(irqs - base), 8'h1);
    $display("test mismatch done");
    wr(ists_pkg::ADDR_TOUT, {2'b10, sel});
    base = irqs;
    mst.start();
    mst.xfer({own, 2'b01}, r);
    acc(1'b0, ists_pkg::ADDR_DATA, 8'h0, q);
    mst.stop();
    repeat (tlim(sel) * 4 + 50) @(posedge hclk);
    chk(8'(irqs - base), 8'h1);
    rc(ists_pkg::ADDR_TOUT, {2'b10, sel});
    mst.start();
    mst.xfer({own, 2'b01}, r);
    n = 0;
    acc(1'b0, ists_pkg::ADDR_DATA, 8'h0, q);
    n = 4;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    chk(8'(n >= tlim(sel) * 4 - 8 && n <= tlim(sel) * 4 + 16), 8'h1);
    rc(ists_pkg::ADDR_TOUT, {2'b01, sel});
    rc(ists_pkg::ADDR_STAT, st(1, 0, 0, 0, 0, 0, 1));
    rc(ists_pkg::ADDR_OWN, {own, 1'b0});
    rc(ists_pkg::ADDR_MODE, 8'hce);
    chk(8'(irqs - base), 8'h3);
    wr(ists_pkg::ADDR_TOUT, 8'h00);
    rc(ists_pkg::ADDR_TOUT, 8'h00);
    mst.stop();
    $display("test timeout done");
    results();
  end
endmodule
